// ==== include/mca_pkg.sv ====
// Shared constants, types and the row-to-group decode function for the micromirror cell array link.
package mca_pkg;
  localparam int COLS = 2560;
  localparam int ROWS = 1600;
  localparam int CELLS = 4096000;
  localparam int WORD_W = 64;
  localparam int BEAT_W = 32;
  localparam int BLOCKS = COLS / WORD_W;
  localparam int GROUPS = 16;
  localparam int ROWS_PER_GROUP = ROWS / GROUPS;
  localparam int ROW_W = 11;
  localparam int COL_W = 12;
  localparam int BLK_W = 6;
  localparam int GRP_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int WORDS_PER_GROUP = ROWS_PER_GROUP * BLOCKS;
  localparam int CNT_W = 13;
  localparam logic [ROW_W-1:0] ROW_LAST = 11'h63f;
  localparam logic [CNT_W-1:0] GROUP_FULL = 13'h0fa0;
  localparam logic PHASE_RISE = 1'h0;
  localparam logic PHASE_FALL = 1'h1;

  typedef enum logic {CMD_LOAD, CMD_RESET} mca_cmd_t;
  typedef enum logic [1:0] {TILT_FLAT, TILT_POS, TILT_NEG} mca_tilt_t;

  typedef struct packed {
    mca_cmd_t cmd;
    logic [ROW_W-1:0] row;
    logic [BLK_W-1:0] blk;
    logic [WORD_W-1:0] data;
  } mca_entry_t;

  localparam int ENTRY_W = $bits(mca_entry_t);

  // Maps a row to the reset group that its mirrors are tied to.
  function automatic logic [GRP_W-1:0] mca_row_group(input logic [ROW_W-1:0] row);
    int g;
    g = int'(row) / ROWS_PER_GROUP;
    return g[GRP_W-1:0];
  endfunction : mca_row_group
endpackage : mca_pkg

// ==== include/mca_link_if.sv ====
// Link between the pattern controller and the micromirror cell array.
`timescale 1ns/100ps
interface mca_link_if;
  import mca_pkg::*;
  logic link_valid;
  logic link_ready;
  logic link_phase;
  mca_cmd_t link_cmd;
  logic [ROW_W-1:0] link_row;
  logic [BLK_W-1:0] link_blk;
  logic [BEAT_W-1:0] lane_p;
  logic [BEAT_W-1:0] lane_n;

  modport dev (
    input link_valid,
    output link_ready,
    input link_phase,
    input link_cmd,
    input link_row,
    input link_blk,
    input lane_p,
    input lane_n
  );

  modport ctl (
    output link_valid,
    input link_ready,
    output link_phase,
    output link_cmd,
    output link_row,
    output link_blk,
    output lane_p,
    output lane_n
  );
endinterface : mca_link_if

// ==== rtl/mca_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module mca_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else if (ce)
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      if (push)
      begin
        mem[wr_ptr] <= in_data;
      end
    end
  end
endmodule : mca_fifo

// ==== rtl/mca_array.sv ====
// Micromirror cell array end: cell storage, reset groups and mirror state.
`timescale 1ns/100ps
module mca_array (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  mca_link_if.dev link,
  input wire logic park,
  input wire logic [mca_pkg::ROW_W-1:0] obs_row,
  input wire logic [mca_pkg::COL_W-1:0] obs_col,
  output logic obs_cell,
  output logic cell_complement_output,
  output mca_pkg::mca_tilt_t obs_tilt,
  output logic [mca_pkg::GROUPS-1:0] mirror_reset_pulse,
  output logic sweep_busy,
  output logic link_error
);
  import mca_pkg::*;

  typedef enum {ST_IDLE, ST_SWEEP} mca_state_t;

  // One storage bit per mirror, and the latched mirror position of each.
  logic [COLS-1:0] cell_mem [ROWS];
  logic [COLS-1:0] mirror_mem [ROWS];

  mca_state_t state;
  mca_state_t next_state;
  logic [ROW_W-1:0] sweep_row;
  logic [ROW_W-1:0] next_sweep_row;
  logic [GROUPS-1:0] sweep_mask;
  logic [GROUPS-1:0] next_sweep_mask;
  logic [GROUPS-1:0] landed;
  logic [GROUPS-1:0] next_landed;
  logic [GROUPS-1:0] next_mirror_reset_pulse;
  logic [BEAT_W-1:0] low_half;
  logic [BEAT_W-1:0] next_low_half;
  logic low_held;
  logic next_low_held;
  logic next_link_error;
  logic next_obs_cell;
  mca_tilt_t next_obs_tilt;

  logic fifo_in_valid;
  logic fifo_in_ready;
  mca_entry_t fifo_in;
  logic fifo_out_valid;
  logic fifo_out_ready;
  mca_entry_t fifo_out;
  logic [ENTRY_W-1:0] fifo_out_bits;

  logic lanes_ok;
  logic load_en;
  logic copy_en;
  logic [GRP_W-1:0] obs_group;

  assign lanes_ok = (link.lane_p == ~link.lane_n);
  assign link.link_ready = (link.link_phase == PHASE_RISE) ? 1'b1 : fifo_in_ready;
  assign fifo_in_valid = link.link_valid && link.link_phase == PHASE_FALL && low_held
    && lanes_ok;
  assign fifo_in = '{cmd: link.link_cmd, row: link.link_row, blk: link.link_blk,
    data: {link.lane_p, low_half}};
  assign fifo_out = mca_entry_t'(fifo_out_bits);
  assign sweep_busy = (state == ST_SWEEP);

  // Link side: pair the rising and falling halves of each differential word.
  always_comb
  begin
    next_low_half = low_half;
    next_low_held = low_held;
    next_link_error = 1'b0;
    if (link.link_valid && link.link_ready)
    begin
      if (!lanes_ok)
      begin
        next_link_error = 1'b1;
        next_low_held = 1'b0;
      end
      else if (link.link_phase == PHASE_RISE)
      begin
        next_low_half = link.lane_p;
        next_low_held = 1'b1;
      end
      else
      begin
        next_link_error = !low_held;
        next_low_held = 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      low_half <= '0;
      low_held <= 1'b0;
      link_error <= 1'b0;
    end
    else if (ce)
    begin
      low_half <= next_low_half;
      low_held <= next_low_held;
      link_error <= next_link_error;
    end
  end

  mca_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) i_mca_fifo (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_bits)
  );

  // Array side: loads go to the cells; a reset sweeps the selected groups.
  always_comb
  begin
    next_state = state;
    next_sweep_row = sweep_row;
    next_sweep_mask = sweep_mask;
    next_landed = landed;
    next_mirror_reset_pulse = '0;
    fifo_out_ready = 1'b0;
    load_en = 1'b0;
    copy_en = 1'b0;
    case (state)
      ST_IDLE:
      begin
        fifo_out_ready = 1'b1;
        if (fifo_out_valid && fifo_out.cmd == CMD_LOAD)
        begin
          load_en = 1'b1;
        end
        else if (fifo_out_valid)
        begin
          next_sweep_mask = fifo_out.data[GROUPS-1:0];
          next_mirror_reset_pulse = fifo_out.data[GROUPS-1:0];
          next_sweep_row = '0;
          next_state = ST_SWEEP;
        end
      end
      ST_SWEEP:
      begin
        copy_en = sweep_mask[mca_row_group(sweep_row)];
        next_sweep_row = sweep_row + 1'b1;
        if (sweep_row == ROW_LAST)
        begin
          next_landed = landed | sweep_mask;
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    if (park)
    begin
      next_landed = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      sweep_row <= '0;
      sweep_mask <= '0;
      landed <= '0;
      mirror_reset_pulse <= '0;
    end
    else if (ce)
    begin
      state <= next_state;
      sweep_row <= next_sweep_row;
      sweep_mask <= next_sweep_mask;
      landed <= next_landed;
      mirror_reset_pulse <= next_mirror_reset_pulse;
    end
  end

  // Cell writes never touch the mirrors; only the sweep copies cells to mirrors.
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (load_en)
      begin
        cell_mem[fifo_out.row][int'(fifo_out.blk) * WORD_W +: WORD_W] <= fifo_out.data;
      end
      if (copy_en)
      begin
        mirror_mem[sweep_row] <= cell_mem[sweep_row];
      end
    end
  end

  // Observation of one cell and its mirror.
  assign obs_group = mca_row_group(obs_row);

  always_comb
  begin
    next_obs_cell = cell_mem[obs_row][obs_col];
    if (!landed[obs_group])
    begin
      next_obs_tilt = TILT_FLAT;
    end
    else if (mirror_mem[obs_row][obs_col])
    begin
      next_obs_tilt = TILT_POS;
    end
    else
    begin
      next_obs_tilt = TILT_NEG;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      obs_cell <= 1'b0;
      cell_complement_output <= 1'b1;
      obs_tilt <= TILT_FLAT;
    end
    else if (ce)
    begin
      obs_cell <= next_obs_cell;
      cell_complement_output <= ~next_obs_cell;
      obs_tilt <= next_obs_tilt;
    end
  end
endmodule : mca_array

// ==== rtl/mca_ctrl.sv ====
// Pattern controller end: takes loads, and resets only of fully loaded groups, streams them over the link.
`timescale 1ns/100ps
module mca_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  mca_link_if.ctl link,
  input wire logic req_valid,
  output logic req_ready,
  input wire mca_pkg::mca_cmd_t req_cmd,
  input wire logic [mca_pkg::ROW_W-1:0] req_row,
  input wire logic [mca_pkg::BLK_W-1:0] req_blk,
  input wire logic [mca_pkg::WORD_W-1:0] req_data,
  input wire logic [mca_pkg::GROUPS-1:0] req_groups,
  output logic req_refused
);
  import mca_pkg::*;

  typedef enum {ST_IDLE, ST_RISE, ST_FALL} mca_ctl_state_t;

  mca_ctl_state_t state;
  mca_ctl_state_t next_state;
  mca_cmd_t cmd;
  mca_cmd_t next_cmd;
  logic [ROW_W-1:0] row;
  logic [ROW_W-1:0] next_row;
  logic [BLK_W-1:0] blk;
  logic [BLK_W-1:0] next_blk;
  logic [WORD_W-1:0] data;
  logic [WORD_W-1:0] next_data;
  logic [CNT_W-1:0] loaded [GROUPS];
  logic [CNT_W-1:0] next_loaded [GROUPS];
  logic next_req_refused;
  logic groups_full;
  logic [GROUPS-1:0] full_vec;
  logic [BEAT_W-1:0] beat;

  genvar gi;
  generate
    for (gi = 0; gi < GROUPS; gi++)
    begin : g_full
      assign full_vec[gi] = (loaded[gi] == GROUP_FULL);
    end
  endgenerate

  assign groups_full = ((req_groups & ~full_vec) == '0);
  assign req_ready = (state == ST_IDLE);
  assign beat = (state == ST_FALL) ? data[WORD_W-1:BEAT_W] : data[BEAT_W-1:0];
  assign link.link_valid = (state != ST_IDLE);
  assign link.link_phase = (state == ST_FALL) ? PHASE_FALL : PHASE_RISE;
  assign link.lane_p = beat;
  assign link.lane_n = ~beat;
  assign link.link_cmd = cmd;
  assign link.link_row = row;
  assign link.link_blk = blk;

  always_comb
  begin
    next_state = state;
    next_cmd = cmd;
    next_row = row;
    next_blk = blk;
    next_data = data;
    next_loaded = loaded;
    next_req_refused = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (req_valid && req_cmd == CMD_LOAD)
        begin
          next_cmd = CMD_LOAD;
          next_row = req_row;
          next_blk = req_blk;
          next_data = req_data;
          if (loaded[mca_row_group(req_row)] != GROUP_FULL)
          begin
            next_loaded[mca_row_group(req_row)] = loaded[mca_row_group(req_row)] + 1'b1;
          end
          next_state = ST_RISE;
        end
        else if (req_valid && groups_full)
        begin
          next_cmd = CMD_RESET;
          next_data = {{(WORD_W-GROUPS){1'b0}}, req_groups};
          for (int g = 0; g < GROUPS; g++)
          begin
            if (req_groups[g])
            begin
              next_loaded[g] = '0;
            end
          end
          next_state = ST_RISE;
        end
        else if (req_valid)
        begin
          next_req_refused = 1'b1;
        end
      end
      ST_RISE:
      begin
        if (link.link_ready)
        begin
          next_state = ST_FALL;
        end
      end
      ST_FALL:
      begin
        if (link.link_ready)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      cmd <= CMD_LOAD;
      row <= '0;
      blk <= '0;
      data <= '0;
      req_refused <= 1'b0;
      for (int g = 0; g < GROUPS; g++)
      begin
        loaded[g] <= '0;
      end
    end
    else if (ce)
    begin
      state <= next_state;
      cmd <= next_cmd;
      row <= next_row;
      blk <= next_blk;
      data <= next_data;
      req_refused <= next_req_refused;
      loaded <= next_loaded;
    end
  end
endmodule : mca_ctrl

// ==== tb/mca_link_checker.sv ====
// Concurrent checks on the link between the controller end and the cell array end.
`timescale 1ns/100ps
module mca_link_checker
  import mca_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic link_valid,
  input wire logic link_ready,
  input wire logic link_phase,
  input wire mca_pkg::mca_cmd_t link_cmd,
  input wire logic [mca_pkg::ROW_W-1:0] link_row,
  input wire logic [mca_pkg::BLK_W-1:0] link_blk,
  input wire logic [mca_pkg::BEAT_W-1:0] lane_p,
  input wire logic [mca_pkg::BEAT_W-1:0] lane_n
);
  logic rise_taken;
  logic fall_taken;
  assign rise_taken = link_valid && link_ready && link_phase == PHASE_RISE;
  assign fall_taken = link_valid && link_ready && link_phase == PHASE_FALL;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_lanes_complement: assert property (link_valid |-> lane_n == ~lane_p)
    else $error("Lane pair is not complementary.");
  a_offer_held: assert property (link_valid && !link_ready |=> link_valid &&
    $stable({link_phase, link_cmd, link_row, link_blk, lane_p}))
    else $error("Offered beat changed before it was taken.");
  a_rise_ready: assert property (link_valid && link_phase == PHASE_RISE |-> link_ready)
    else $error("Rise beat was not accepted at once.");
  a_rise_then_fall: assert property (rise_taken |=> link_valid && link_phase == PHASE_FALL)
    else $error("Rise beat not followed by its fall beat.");
  a_word_opens_rise: assert property ($rose(link_valid) |-> link_phase == PHASE_RISE)
    else $error("Word opened with a fall beat.");
  a_header_both: assert property (rise_taken |=> $stable({link_cmd, link_row, link_blk}))
    else $error("Header changed between the two beats.");
  a_cell_in_grid: assert property (link_valid && link_cmd == CMD_LOAD |->
    link_row <= ROW_LAST && link_blk < 6'h28)
    else $error("Load addresses a cell outside the grid.");
  a_word_closes: assert property (fall_taken |=> !link_valid)
    else $error("Controller offered a new beat right after a word.");
  c_rise: cover property (rise_taken);
  c_fall_stall: cover property (link_valid && link_phase == PHASE_FALL && !link_ready);
  c_reset_sent: cover property (fall_taken && link_cmd == CMD_RESET);
endmodule : mca_link_checker

// ==== tb/micromirror_cell_array_update_bench.sv ====
// Self-checking bench joining the controller end and the cell array end over the link.
`timescale 1ns/100ps
module micromirror_cell_array_update_bench;
  import mca_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic park = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready;
  logic req_refused;
  mca_cmd_t req_cmd = CMD_LOAD;
  logic [ROW_W-1:0] req_row = 11'h000;
  logic [BLK_W-1:0] req_blk = 6'h00;
  logic [WORD_W-1:0] req_data = 64'h0;
  logic [GROUPS-1:0] req_groups = 16'h0000;
  logic [ROW_W-1:0] obs_row = 11'h000;
  logic [COL_W-1:0] obs_col = 12'h000;
  logic obs_cell;
  logic cell_complement_output;
  mca_tilt_t obs_tilt;
  logic [GROUPS-1:0] mirror_reset_pulse;
  logic [GROUPS-1:0] last_pulse = 16'h0000;
  logic sweep_busy;
  logic link_error;
  logic stalled = 1'b0;
  logic b;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int refusals = 0;
  mca_link_if link();
  mca_ctrl i_mca_ctrl (.clk(clk), .resetn(resetn), .ce(1'b1), .link(link),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_row(req_row),
    .req_blk(req_blk), .req_data(req_data), .req_groups(req_groups),
    .req_refused(req_refused));
  mca_array i_mca_array (.clk(clk), .resetn(resetn), .ce(1'b1), .link(link), .park(park),
    .obs_row(obs_row), .obs_col(obs_col), .obs_cell(obs_cell),
    .cell_complement_output(cell_complement_output), .obs_tilt(obs_tilt),
    .mirror_reset_pulse(mirror_reset_pulse), .sweep_busy(sweep_busy),
    .link_error(link_error));
  mca_link_checker i_mca_link_checker (.clk(clk), .resetn(resetn),
    .link_valid(link.link_valid), .link_ready(link.link_ready),
    .link_phase(link.link_phase), .link_cmd(link.link_cmd), .link_row(link.link_row),
    .link_blk(link.link_blk), .lane_p(link.lane_p), .lane_n(link.lane_n));
  always #10 clk = ~clk;

  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask : check

  always @(posedge clk)
  begin
    cycles++;
    if (req_refused === 1'b1)
      refusals++;
    if (|mirror_reset_pulse)
      last_pulse = mirror_reset_pulse;
    if (resetn)
      check(64'h0, 64'(link_error));
    if (cycles == 70000)
    begin
      errors++;
      report_and_stop();
    end
  end

  function automatic logic [63:0] pat(input int r, input int k);
    return {r[ROW_W-1:0], k[BLK_W-1:0], 47'h0} ^ 64'hc3a5_5a3c_9669_0ff0;
  endfunction : pat

  // Expected stored bit of one cell, taken from the word that loads its block.
  function automatic logic pb(input int r, input int c);
    logic [63:0] w;
    w = pat(r, c / WORD_W);
    return w[c % WORD_W];
  endfunction : pb

  function automatic mca_tilt_t tl(input logic v);
    return v ? TILT_POS : TILT_NEG;
  endfunction : tl

  // Offers one request and holds it until the controller takes it.
  task automatic send(input mca_cmd_t c, input int r, input int k, input logic [63:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_cmd = c;
    req_row = r[ROW_W-1:0];
    req_blk = k[BLK_W-1:0];
    req_data = d;
    req_groups = d[15:0];
    while (req_ready !== 1'b1 && n < 3000)
    begin
      n++;
      @(posedge clk);
      #1;
    end
    if (n > 2)
      stalled = 1'b1;
    if (n == 3000)
      errors++;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
  endtask : send

  task automatic load_group(input int g);
    for (int r = g * ROWS_PER_GROUP; r < (g + 1) * ROWS_PER_GROUP; r++)
      for (int k = 0; k < BLOCKS; k++)
        send(CMD_LOAD, r, k, pat(r, k));
  endtask : load_group

  task automatic wait_sweep();
    int n;
    n = 0;
    while (sweep_busy !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    while (sweep_busy !== 1'b0 && n < 2200)
    begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
  endtask : wait_sweep

  // Selects one cell and compares its stored bit, complement and tilt.
  task automatic observe(input int r, input int c, input logic v, input mca_tilt_t t);
    @(posedge clk);
    #1;
    obs_row = r[ROW_W-1:0];
    obs_col = c[COL_W-1:0];
    repeat (3) @(posedge clk);
    #1;
    check(64'(v), 64'(obs_cell));
    check(64'(!v), 64'(cell_complement_output));
    check(64'(t), 64'(obs_tilt));
  endtask : observe

  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
    load_group(0);
    b = pb(37, 132);
    observe(37, 132, b, TILT_FLAT);
    send(CMD_RESET, 0, 0, 64'h4);
    repeat (3) @(posedge clk);
    check(64'h1, 64'(refusals));
    send(CMD_RESET, 0, 0, 64'h1);
    wait_sweep();
    check(64'h1, 64'(last_pulse));
    observe(37, 132, b, TILT_POS);
    observe(37, 128, pb(37, 128), TILT_NEG);
    send(CMD_LOAD, 37, 2, ~pat(37, 2));
    observe(37, 132, ~b, tl(b));
    load_group(1);
    observe(150, 70, pb(150, 70), TILT_FLAT);
    send(CMD_RESET, 0, 0, 64'h2);
    load_group(2);
    check(64'h1, 64'(stalled));
    wait_sweep();
    check(64'h2, 64'(last_pulse));
    observe(150, 70, pb(150, 70), tl(pb(150, 70)));
    observe(250, 640, pb(250, 640), TILT_FLAT);
    observe(37, 132, ~b, tl(b));
    send(CMD_RESET, 0, 0, 64'h4);
    wait_sweep();
    check(64'h4, 64'(last_pulse));
    observe(250, 644, pb(250, 644), tl(pb(250, 644)));
    park = 1'b1;
    observe(250, 644, pb(250, 644), TILT_FLAT);
    park = 1'b0;
    observe(150, 70, pb(150, 70), TILT_FLAT);
    report_and_stop();
  end
endmodule : micromirror_cell_array_update_bench
